/* src/sps_pkg.sv */
// Package of constants and carrier types for the stall prevention supervisor.
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - Current above level steers frequency to lower it.
// - Current above fast limit shuts drive off.
// - Stall level 0.1-150%, default 120%, 0 disables.
// - Percent of inverter or PM motor rated current.
// - Accel decelerates, constant decelerates, decel accelerates.
// - High-speed factor 0-200%, 9999 keeps level constant.
// - Reduction start frequency 0-400Hz, default 60Hz.
// - Second level 0, 0.1-150%, 9999 equals primary.
// - Second-function select uses the second level.
// - Overvoltage suppress select: 1 off, 11 on.
// - Behaviour select 0-31, 100, 101 gates actions.
// - Stall flag asserted for longer than 100ms.
// - Flag drops when current at or below level.
// - Flag delay: 0 now, 0.1-25s delayed, 9999 never.
// - Flag also set by regen avoidance or overvoltage stall.
// - Terminal code 3 active-high, 103 active-low.
// - At 1Hz for 3s under stall, fault and trip.
package sps_pkg;

	// Clock and time bases.
	localparam int CLK_HZ          = 50_000_000;
	localparam int MS_PER_S        = 1000;
	localparam int TICK_MS         = 100;
	localparam int TICK_CYC        = CLK_HZ / MS_PER_S * TICK_MS;
	localparam int MIN_HOLD_MS     = 100;
	localparam int MIN_HOLD_TICKS  = MIN_HOLD_MS / TICK_MS + 1;
	localparam int FAULT_TIME_S    = 3;
	localparam int FAULT_TICKS     = FAULT_TIME_S * MS_PER_S / TICK_MS;

	// Setting encodings; percents and hertz in tenths, delay in 0.1 s.
	localparam logic [15:0] SETTING_9999    = 16'h270F;
	localparam logic [15:0] LEVEL_MAX       = 16'h05DC;
	localparam logic [15:0] LEVEL_DEFAULT   = 16'h04B0;
	localparam logic [15:0] FACTOR_MAX      = 16'h07D0;
	localparam logic [15:0] FACTOR_UNITY    = 16'h03E8;
	localparam logic [15:0] FREQ_MAX        = 16'h0FA0;
	localparam logic [15:0] REDUCE_DEFAULT  = 16'h0258;
	localparam logic [15:0] FREQ_FLOOR      = 16'h000A;
	localparam logic [15:0] DELAY_MAX       = 16'h00FA;
	localparam logic [7:0]  OVS_OFF         = 8'h01;
	localparam logic [7:0]  OVS_ON          = 8'h0B;
	localparam logic [7:0]  BEH_MAX         = 8'h1F;
	localparam logic [7:0]  BEH_100         = 8'h64;
	localparam logic [7:0]  BEH_101         = 8'h65;
	localparam logic [7:0]  TERM_POS        = 8'h03;
	localparam logic [7:0]  TERM_NEG        = 8'h67;

	// Parameter settings carried together.
	typedef struct packed {
		logic [15:0] stall_level_setting;
		logic [15:0] high_speed_level_factor;
		logic [15:0] second_stall_level;
		logic [15:0] level_reduction_start_freq;
		logic [7:0]  overvoltage_suppress_select;
		logic [7:0]  stall_behavior_select;
		logic [15:0] overload_flag_delay;
		logic [7:0]  output_terminal_assign_a;
		logic [7:0]  output_terminal_assign_b;
	} sps_settings_s;

	// Drive state from the ramp generator.
	typedef struct packed {
		logic        accelerating;
		logic        decelerating;
		logic [15:0] output_freq;
		logic [15:0] output_current;
	} sps_drive_s;

	// Frequency adjustment command.
	typedef enum logic [1:0] {
		SPS_ADJ_NONE,
		SPS_ADJ_HOLD,
		SPS_ADJ_DOWN,
		SPS_ADJ_UP
	} sps_adj_e;

endpackage

/* src/sps_supervisor.sv */
// Stall prevention supervisor: level select, action, flag and fault.
`timescale 1ns/100ps

module sps_supervisor
	import sps_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset.
	input  wire logic          mclk_in,
	input  wire logic          rst_n_in,
	// Settings and drive state.
	input  wire sps_settings_s settings_in,
	input  wire sps_drive_s    drive_in,
	input  wire logic [15:0]   fast_limit_in,
	input  wire logic          pm_motor_mode_in,
	// Asynchronous status pins.
	input  wire logic          second_function_select_in,
	input  wire logic          regen_avoid_active_in,
	input  wire logic          ov_stall_active_in,
	// Drive commands.
	output sps_adj_e           freq_adjust_out,
	output logic               drive_shutoff_out,
	output logic               ov_suppress_out,
	output logic               stall_frequency_fault_out,
	// Flag and terminals.
	output logic               stall_active_flag_out,
	output logic               terminal_a_out,
	output logic               terminal_b_out,
	output logic               settings_error_out
);

	//--------------------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------------------
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;

	// Two flops per asynchronous pin; only stage two is read.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 3'h0;
			sync2_ff <= 3'h0;
		end else begin
			sync1_ff <= {ov_stall_active_in, regen_avoid_active_in,
				second_function_select_in};
			sync2_ff <= sync1_ff;
		end
	end

	wire second_sel = sync2_ff[0];
	wire ext_stall  = sync2_ff[1] | sync2_ff[2];

	//--------------------------------------------------------------------------
	// Active level
	//--------------------------------------------------------------------------
	logic [15:0] base_level;
	logic [15:0] active_level;
	logic [31:0] scaled;
	logic        beh_ok;
	logic        stall_en;
	logic        fast_en;

	// Level selection, high-speed reduction and behaviour decode.
	always_comb begin
		base_level = settings_in.stall_level_setting;
		if (second_sel &&
			settings_in.second_stall_level != SETTING_9999) begin
			base_level = settings_in.second_stall_level;
		end
		// Zero or out of range disables the stall level.
		if (base_level > LEVEL_MAX) begin
			base_level = 16'h0000;
		end
		active_level = base_level;
		scaled = 32'h0;
		// Level scaled by start over output frequency above the start frequency.
		if (settings_in.high_speed_level_factor != SETTING_9999 &&
			settings_in.high_speed_level_factor <= FACTOR_MAX &&
			drive_in.output_freq > settings_in.level_reduction_start_freq &&
			settings_in.level_reduction_start_freq <= FREQ_MAX) begin
			scaled = 32'(base_level) *
				32'(settings_in.level_reduction_start_freq) /
				32'(drive_in.output_freq);
			active_level = scaled[15:0];
			if (active_level == 16'h0000 && base_level != 16'h0000) begin
				active_level = 16'h0001;
			end
		end
		beh_ok = settings_in.stall_behavior_select <= BEH_MAX ||
			settings_in.stall_behavior_select == BEH_100 ||
			settings_in.stall_behavior_select == BEH_101;
		stall_en = beh_ok && active_level != 16'h0000;
		fast_en  = beh_ok && settings_in.stall_behavior_select[3] == 1'b0;
	end

	// The current input is already scaled to the rated current
	// of the motor in use; the mode only documents the reference.
	wire over_level = stall_en && (drive_in.output_current > active_level);

	//--------------------------------------------------------------------------
	// Frequency action and shutoff
	//--------------------------------------------------------------------------
	// Choose direction that lowers the current.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			freq_adjust_out <= SPS_ADJ_NONE;
		end else if (!over_level) begin
			freq_adjust_out <= SPS_ADJ_NONE;
		end else if (drive_in.accelerating) begin
			freq_adjust_out <= SPS_ADJ_DOWN;
		end else if (drive_in.decelerating) begin
			freq_adjust_out <= SPS_ADJ_UP;
		end else begin
			freq_adjust_out <= SPS_ADJ_DOWN;
		end
	end

	// Fast limit cuts the drive at once and holds for the cycle.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drive_shutoff_out <= 1'b0;
		end else begin
			drive_shutoff_out <= fast_en &&
				drive_in.output_current > fast_limit_in;
		end
	end

	// Overvoltage suppression only while stall action runs.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ov_suppress_out <= 1'b0;
		end else begin
			ov_suppress_out <= over_level &&
				settings_in.overvoltage_suppress_select == OVS_ON;
		end
	end

	// Flags behaviour and overvoltage select codes that are outside the accepted ranges.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settings_error_out <= 1'b0;
		end else begin
			settings_error_out <= !beh_ok ||
				(settings_in.overvoltage_suppress_select != OVS_OFF &&
				settings_in.overvoltage_suppress_select != OVS_ON);
		end
	end

	//--------------------------------------------------------------------------
	// Time base
	//--------------------------------------------------------------------------
	logic [31:0] div_ff;
	logic        tick_ff;

	// One pulse each 100 ms.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_ff  <= 32'h0;
			tick_ff <= 1'b0;
		end else if (div_ff == 32'(TICK_CYCLES - 1)) begin
			div_ff  <= 32'h0;
			tick_ff <= 1'b1;
		end else begin
			div_ff  <= div_ff + 32'h1;
			tick_ff <= 1'b0;
		end
	end

	//--------------------------------------------------------------------------
	// Stall-active flag
	//--------------------------------------------------------------------------
	logic [15:0] delay_ff;
	logic [7:0]  hold_ff;
	logic        flag_ff;
	wire         stall_cond = over_level || ext_stall;
	wire         delay_off  = settings_in.overload_flag_delay == SETTING_9999;
	wire         delay_done = delay_ff >= settings_in.overload_flag_delay;

	// Count continuous stall time; restart when it ends.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			delay_ff <= 16'h0;
		end else if (!stall_cond) begin
			delay_ff <= 16'h0;
		end else if (tick_ff && !delay_done) begin
			delay_ff <= delay_ff + 16'h1;
		end
	end

	// Assert after delay, hold past 100 ms, drop at level.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flag_ff <= 1'b0;
			hold_ff <= 8'h0;
		end else if (stall_cond && delay_done && !delay_off) begin
			if (!flag_ff) begin
				hold_ff <= 8'(MIN_HOLD_TICKS);
			end else if (tick_ff && hold_ff != 8'h0) begin
				hold_ff <= hold_ff - 8'h1;
			end
			flag_ff <= 1'b1;
		end else if (flag_ff && hold_ff != 8'h0) begin
			if (tick_ff) begin
				hold_ff <= hold_ff - 8'h1;
			end
		end else begin
			flag_ff <= 1'b0;
		end
	end

	assign stall_active_flag_out = flag_ff;

	// Terminal mapping by function code.
	function automatic logic term_map(input logic [7:0] code,
		input logic flag);
		if (code == TERM_POS) begin
			term_map = flag;
		end else if (code == TERM_NEG) begin
			term_map = !flag;
		end else begin
			term_map = 1'b0;
		end
	endfunction

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			terminal_a_out <= 1'b0;
			terminal_b_out <= 1'b0;
		end else begin
			terminal_a_out <= term_map(settings_in.output_terminal_assign_a,
				flag_ff);
			terminal_b_out <= term_map(settings_in.output_terminal_assign_b,
				flag_ff);
		end
	end

	//--------------------------------------------------------------------------
	// Stall frequency fault
	//--------------------------------------------------------------------------
	logic [7:0] low_ff;
	wire        at_floor = over_level && drive_in.output_freq <= FREQ_FLOOR;

	// Time at 1 Hz under stall action; fault latches until reset.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_ff                    <= 8'h0;
			stall_frequency_fault_out <= 1'b0;
		end else if (!at_floor) begin
			low_ff <= 8'h0;
		end else if (tick_ff) begin
			if (low_ff == 8'(FAULT_TICKS - 1)) begin
				stall_frequency_fault_out <= 1'b1;
			end else begin
				low_ff <= low_ff + 8'h1;
			end
		end
	end

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	sequence s_flag_rise;
		!flag_ff ##1 flag_ff;
	endsequence

	chk_shutoff_on_limit: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		(fast_en && drive_in.output_current > fast_limit_in)
		|=> drive_shutoff_out)
		else $error("Drive not shut off above fast limit.");

	chk_accel_decel_dir: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		(over_level && drive_in.accelerating) |=>
		freq_adjust_out == SPS_ADJ_DOWN)
		else $error("Acceleration not reversed under stall.");

	chk_decel_reverse: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		(over_level && !drive_in.accelerating && drive_in.decelerating)
		|=> freq_adjust_out == SPS_ADJ_UP)
		else $error("Deceleration not reversed under stall.");

	chk_no_adjust_idle: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		!over_level |=> freq_adjust_out == SPS_ADJ_NONE)
		else $error("Adjustment without stall.");

	chk_flag_hold_min: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		s_flag_rise |-> hold_ff != 8'h0 ##1 flag_ff [*8])
		else $error("Stall flag dropped too early.");

	chk_flag_never: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		delay_off && $past(delay_off) && !flag_ff |=> !flag_ff)
		else $error("Stall flag raised though disabled.");

	chk_delay_restart: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		!stall_cond |=> delay_ff == 16'h0)
		else $error("Delay counter not restarted.");

	chk_term_polarity: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		settings_in.output_terminal_assign_a == TERM_NEG
		&& $stable(settings_in.output_terminal_assign_a)
		|=> terminal_a_out == !$past(flag_ff))
		else $error("Negative terminal polarity wrong.");

	chk_fault_sticky: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		stall_frequency_fault_out |=> stall_frequency_fault_out)
		else $error("Stall frequency fault not held.");

	chk_fault_cause: assert property (@(posedge mclk_in)
		disable iff (!rst_n_in)
		$rose(stall_frequency_fault_out) |->
		$past(at_floor) && $past(low_ff) == 8'(FAULT_TICKS - 1))
		else $error("Fault raised without 3 s at floor.");

endmodule // sps_supervisor

/* test/sps_drive_model.sv */
// Behavioural drive stage that ramps output frequency on adjust commands.
`timescale 1ns/100ps

module sps_drive_model
	import sps_pkg::*;
(
	// Clock and reset.
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// Commands from the supervisor and the bench.
	input  wire sps_adj_e    adj_in,
	input  wire logic        load_in,
	input  wire logic [15:0] freq_in,
	// Output frequency seen by the supervisor.
	output logic [15:0]      freq_out
);
	// Ramp one step a cycle, clamped at the 1 Hz floor and the top.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			freq_out <= 16'h0000;
		else if (load_in)
			freq_out <= freq_in;
		else if (adj_in == SPS_ADJ_DOWN && freq_out > FREQ_FLOOR)
			freq_out <= freq_out - 16'h0001;
		else if (adj_in == SPS_ADJ_UP && freq_out < FREQ_MAX)
			freq_out <= freq_out + 16'h0001;
	end
endmodule // sps_drive_model

/* test/stall_prevention_supervisor_test.sv */
// Self-checking bench for the stall prevention supervisor.
`timescale 1ns/100ps

module stall_prevention_supervisor_test;
	import sps_pkg::*;
	localparam int TK = 10;
	logic          mclk_in = 1'b0;
	logic          rst_n_in = 1'b0;
	sps_settings_s st;
	sps_drive_s    drv;
	logic          acc, dec, ld, sfs, rgn, ovst, pmm;
	logic [15:0]   cur, fset, lim, mfreq;
	sps_adj_e      adj;
	logic          shut, ovsup, flt, flag, ta, tb_o, serr;
	logic          pf = 1'b0, ps = 1'b0, pt = 1'b0;
	logic [7:0]    pca = 8'h00, pcb = 8'h00;
	logic          qf[$], qs[$], qt[$];
	int            n_fail = 0, cmp_count = 0, cyc = 0, rc = 0;

	assign drv = '{acc, dec, mfreq, cur};

	sps_supervisor #(.TICK_CYCLES(TK)) dut (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .settings_in(st),
		.drive_in(drv), .fast_limit_in(lim), .pm_motor_mode_in(pmm),
		.second_function_select_in(sfs), .regen_avoid_active_in(rgn),
		.ov_stall_active_in(ovst), .freq_adjust_out(adj),
		.drive_shutoff_out(shut), .ov_suppress_out(ovsup),
		.stall_frequency_fault_out(flt), .stall_active_flag_out(flag),
		.terminal_a_out(ta), .terminal_b_out(tb_o),
		.settings_error_out(serr));

	sps_drive_model drv_model (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .adj_in(adj),
		.load_in(ld), .freq_in(fset), .freq_out(mfreq));

	// Free-running 50 MHz clock.
	initial begin
		forever #10 mclk_in = ~mclk_in;
	end

	//--------------------------------------------------------------------
	// Compare tasks
	//--------------------------------------------------------------------
	task automatic check_bit(string nm, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic check_adj(sps_adj_e e, sps_adj_e g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] freq_adjust expected %s seen %s", e.name(), g.name());
		end
	endtask
	task automatic take(ref logic q[$], input string nm, input logic g);
		if (q.size() == 0) begin
			cmp_count++;
			n_fail++;
			$display("[ERR] %s expected no change seen %b", nm, g);
		end else
			check_bit(nm, q.pop_front(), g);
	endtask
	task automatic step(int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic wait_adj(sps_adj_e e, int n);
		for (int i = 0; i < n && adj !== e; i++)
			step(1);
		check_adj(e, adj);
	endtask
	task automatic hold_adj(sps_adj_e e, int n);
		repeat (n) begin
			step(1);
			check_adj(e, adj);
		end
	endtask
	task automatic setf(logic [15:0] f);
		fset = f;
		ld = 1'b1;
		step(1);
		ld = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Keep the terminal codes that the design sampled at each edge.
	always @(posedge mclk_in) begin
		pca <= st.output_terminal_assign_a;
		pcb <= st.output_terminal_assign_b;
	end

	// Take the oldest note off a queue whenever a watched output moves.
	always @(negedge mclk_in) begin
		cyc++;
		if (cyc > 8) begin
			check_bit("terminal_a", pca == TERM_POS ? pf :
				pca == TERM_NEG && !pf, ta);
			check_bit("terminal_b", pcb == TERM_POS ? pf :
				pcb == TERM_NEG && !pf, tb_o);
			if (flag !== pf) take(qf, "stall_active_flag", flag);
			if (flag && !pf) rc = cyc;
			if (!flag && pf) check_bit("flag_hold", 1'b1, cyc - rc > TK);
			if (shut !== ps) take(qs, "drive_shutoff", shut);
			if (flt !== pt) take(qt, "stall_frequency_fault", flt);
		end
		pf = flag;
		ps = shut;
		pt = flt;
	end

	// Watchdog that cuts a hung run short.
	initial begin
		repeat (40000) @(posedge mclk_in);
		n_fail++;
		tally_and_finish();
	end

	//--------------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------------
	initial begin
		st = '{LEVEL_DEFAULT, SETTING_9999, SETTING_9999, REDUCE_DEFAULT,
			OVS_OFF, 8'h00, 16'h0000, TERM_POS, TERM_NEG};
		{acc, dec, ld, sfs, rgn, ovst} = 6'h00;
		cur = 16'h0000;
		fset = REDUCE_DEFAULT;
		void'($urandom(48));
		lim = 16'h0780 + 16'($urandom_range(80));
		pmm = 1'($urandom);
		repeat (4) @(posedge mclk_in);
		@(negedge mclk_in) rst_n_in = 1'b1;
		step(4);
		// Accelerating, constant and decelerating stalls, random overload.
		for (int m = 0; m < 3; m++) begin
			acc = (m == 0);
			dec = (m == 2);
			pmm = 1'($urandom);
			st.output_terminal_assign_a = m == 1 ? TERM_NEG : TERM_POS;
			st.output_terminal_assign_b = m == 0 ? TERM_NEG :
				m == 1 ? TERM_POS : 8'($urandom_range(2));
			setf(REDUCE_DEFAULT);
			qf.push_back(1'b1);
			cur = 16'h04B1 + 16'($urandom_range(700));
			wait_adj(m == 2 ? SPS_ADJ_UP : SPS_ADJ_DOWN, 4);
			qf.push_back(1'b0);
			cur = LEVEL_DEFAULT;
			wait_adj(SPS_ADJ_NONE, 4);
			step(5 * TK);
		end
		{acc, dec} = 2'b00;
		st.output_terminal_assign_b = TERM_NEG;
		// Zero level disables stall action.
		st.stall_level_setting = 16'h0000;
		cur = 16'h0514;
		hold_adj(SPS_ADJ_NONE, 20);
		// Fast limit: at the limit nothing, above it shutoff, bit3 masks.
		cur = lim;
		step(4);
		qs.push_back(1'b1);
		cur = lim + 16'h0001;
		step(4);
		qs.push_back(1'b0);
		cur = 16'h0000;
		step(4);
		st.stall_behavior_select = 8'h08;
		cur = lim + 16'h0001;
		step(6);
		cur = 16'h0000;
		st.stall_level_setting = LEVEL_DEFAULT;
		// Selector range: valid and invalid codes.
		for (int i = 0; i < 4; i++) begin
			st.stall_behavior_select = i == 0 ? BEH_100 : i == 1 ? BEH_101 :
				i == 2 ? BEH_MAX : 8'h20;
			st.overvoltage_suppress_select = i == 1 ? 8'h05 : OVS_ON;
			step(3);
			check_bit("settings_error", i >= 1 && i != 2, serr);
		end
		st.stall_behavior_select = 8'h00;
		// Overvoltage suppression follows the select during a stall.
		qf.push_back(1'b1);
		cur = 16'h0514;
		step(4);
		check_bit("ov_suppress", 1'b1, ovsup);
		st.overvoltage_suppress_select = OVS_OFF;
		step(3);
		check_bit("ov_suppress", 1'b0, ovsup);
		qf.push_back(1'b0);
		cur = 16'h0000;
		step(5 * TK);
		// Second level under the select input; 0 and 9999 cases.
		st.second_stall_level = 16'h0320;
		cur = 16'h03E8;
		qf.push_back(1'b1);
		sfs = 1'b1;
		wait_adj(SPS_ADJ_DOWN, 6);
		qf.push_back(1'b0);
		sfs = 1'b0;
		wait_adj(SPS_ADJ_NONE, 6);
		step(5 * TK);
		sfs = 1'b1;
		st.second_stall_level = 16'h0000;
		hold_adj(SPS_ADJ_NONE, 10);
		st.second_stall_level = SETTING_9999;
		hold_adj(SPS_ADJ_NONE, 10);
		qf.push_back(1'b1);
		cur = 16'h04B1;
		wait_adj(SPS_ADJ_DOWN, 4);
		qf.push_back(1'b0);
		sfs = 1'b0;
		cur = 16'h0000;
		step(5 * TK);
		// Flag delay restarts when the stall ends early; 9999 never flags.
		st.overload_flag_delay = 16'h0003;
		repeat (2) begin
			cur = 16'h0514;
			step(15);
			cur = 16'h0000;
			step(5);
		end
		qf.push_back(1'b1);
		cur = 16'h0514;
		step(6 * TK);
		qf.push_back(1'b0);
		cur = 16'h0000;
		step(5 * TK);
		st.overload_flag_delay = SETTING_9999;
		cur = 16'h0514;
		step(6 * TK);
		cur = 16'h0000;
		step(TK);
		st.overload_flag_delay = 16'h0000;
		// Regeneration avoidance and overvoltage stall raise the flag.
		for (int i = 0; i < 2; i++) begin
			qf.push_back(1'b1);
			{rgn, ovst} = i == 0 ? 2'b10 : 2'b01;
			step(2 * TK);
			qf.push_back(1'b0);
			{rgn, ovst} = 2'b00;
			step(5 * TK);
		end
		// High-speed reduction: off at 9999 or high start, on otherwise.
		setf(16'h04B0);
		cur = 16'h03E8;
		hold_adj(SPS_ADJ_NONE, 8);
		st.high_speed_level_factor = FACTOR_UNITY;
		st.level_reduction_start_freq = FREQ_MAX;
		hold_adj(SPS_ADJ_NONE, 8);
		qf.push_back(1'b1);
		qf.push_back(1'b0);
		st.level_reduction_start_freq = REDUCE_DEFAULT;
		wait_adj(SPS_ADJ_DOWN, 6);
		step(600);
		cur = 16'h0000;
		step(5 * TK);
		st.high_speed_level_factor = SETTING_9999;
		// Stall pinned at the 1 Hz floor trips after 3 s.
		setf(16'h0064);
		qf.push_back(1'b1);
		cur = 16'h0514;
		step(28 * TK);
		qt.push_back(1'b1);
		step(8 * TK + 100);
		check_bit("fault_seen", 1'b1, qt.size() == 0);
		tally_and_finish();
	end
endmodule // stall_prevention_supervisor_test
